/* File: logic/serial_port_pkg.sv */
// constants, field layout and types for the four-mode serial port
// assumes a single 20 MHz peripheral clock and an AHB-Lite register slave
//
// Function
// - two mode bits pick shift register, 8-bit async or 9-bit async.
// - shift mode: data in on receive line, out on data line, clock on transmit line.
// - shift mode transmit starts on buffer write, shifts right, flag after final shift.
// - shift mode receive starts when enabled and flag clear; preload 11111110, shift left.
// - zero at leftmost: one last shift, load buffer, set receive flag; half clock rate.
// - 8-bit async frame: zero start, eight data bits LSB first, one stop bit.
// - async transmit starts on the next divide-by-16 rollover tick; the line follows one clock later.
// - async receive: falling edge at 16x rate, counter reset, ones preload, 2-of-3 vote.
// - 8-bit async end: load data and stop bit; flag only if clear and filter passes.
// - 9-bit frame: start, eight data, programmable ninth bit, stop.
// - 9-bit transmit sends the ninth-bit control, then a one stop bit, then the flag.
// - 9-bit receive end: load data and ninth bit; flag only if clear and filter passes.
// - shift mode runs at half the clock; fixed 9-bit mode at one sixty-fourth.
// - variable 9-bit mode equals fixed 9-bit mode except for its bit timing source.
// - any buffer write starts transmit; async receive needs a start bit and enable.
// - done flags raise requests on frame end and stay readable for polling.
// - 9-bit mode with filter on flags only frames whose ninth bit is one.
// - filter bit ignored in shift mode; in 8-bit async it demands a valid stop bit.
// - variable modes take a 16x baud tick and divide it by sixteen.
// - buffer writes load transmit holding, reads return a separate receive register.
// - receiver may start a second frame before the first is read; one may be lost.
package serial_port_pkg;

	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] DATA_OFFSET = 8'h04;
	localparam logic [7:0] STATUS_OFFSET = 8'h08;
	localparam int STAT_TX_BUSY_BIT = 0;
	localparam int STAT_RX_BUSY_BIT = 1;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	localparam logic [1:0] MODE_SHIFT = 2'h0;
	localparam logic [1:0] MODE_ASYNC8 = 2'h1;
	localparam logic [1:0] MODE_FIXED9 = 2'h2;
	localparam logic [1:0] MODE_VAR9 = 2'h3;

	localparam int PCLK_HZ = 20_000_000;
	localparam int MC_CLKS = 2;
	localparam int FIXED9_DIVISOR = 64;
	localparam int OVERSAMPLE = 16;
	localparam int FIXED9_TICK_CLKS = FIXED9_DIVISOR / OVERSAMPLE;
	localparam logic [3:0] SAMPLE_A = 4'h7;
	localparam logic [3:0] SAMPLE_B = 4'h8;
	localparam logic [3:0] SAMPLE_C = 4'h9;
	localparam logic [3:0] ROLLOVER = 4'hf;

	localparam logic [3:0] MODE0_BITS = 4'h8;
	localparam logic [3:0] FRAME8_BITS = 4'ha;
	localparam logic [3:0] FRAME9_BITS = 4'hb;
	localparam logic [7:0] RX_SHIFT_PRELOAD = 8'hfe;
	localparam logic [10:0] RX_ASYNC_PRELOAD = 11'h7ff;

	typedef struct packed {
		logic mode_select_high;
		logic mode_select_low;
		logic multiproc_filter_en;
		logic receiveEnable;
		logic tx_ninth_bit;
		logic rx_ninth_bit;
		logic transmit_done_flag;
		logic receive_done_flag;
	} serial_control_reg_t;

	localparam serial_control_reg_t CTRL_RESET = 8'h00;

	typedef struct packed {
		logic finish;
		logic ninth;
		logic [7:0] data;
	} rx_result_t;

	typedef enum {TX_IDLE, TX_ACTIVE} tx_state_t;
	typedef enum {RX_IDLE, RX_MODE0, RX_START, RX_FRAME} rx_state_t;

endpackage : serial_port_pkg

/* File: logic/four_mode_serial_port.sv */
// four-mode serial port with AHB-Lite register slave
// assumes all inputs synchronous to core_clk; baudTick16 is a one-cycle pulse at 16x bit rate
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module four_mode_serial_port import serial_port_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic baudTick16,
	input wire logic rxdIn,
	output logic txdOut,
	output logic shift_data_out_line,
	output logic txDoneFlag,
	output logic rxDoneFlag
);

	serial_control_reg_t serial_control_reg_ff;
	logic [7:0] txHold_ff;
	logic [7:0] rxBuf_ff;
	logic wrPend_ff;
	logic [7:0] wrAddr_ff;
	logic [31:0] hrdata_ff;
	logic hreadyout_ff;
	logic hresp_ff;

	logic mcPhase_ff;
	logic [1:0] fixDiv_ff;
	logic [3:0] txCnt_ff;

	tx_state_t txState_ff;
	logic txPend_ff;
	logic [10:0] txSh_ff;
	logic [3:0] txLeft_ff;
	logic txBit_ff;
	logic txFinish_ff;
	logic txdOut_ff;
	logic shiftOut_ff;

	rx_state_t rxState_ff;
	logic [10:0] rxSh_ff;
	logic [3:0] rxCnt_ff;
	logic [1:0] rxSamp_ff;
	logic rxPrev_ff;
	rx_result_t rxRes_ff;

	logic [1:0] mode;
	logic isShift;
	logic isNine;
	logic addrPhase;
	logic ctrlWr;
	logic dataWr;
	logic mcEn;
	logic fixTick;
	logic tick16;
	logic txRoll;
	logic txStep;
	logic txBusy;
	logic rxBusy;
	logic rxDoneNow;
	logic rxAccept;
	logic [10:0] txFrame;
	logic [3:0] txLen;
	logic vote;
	logic [10:0] rxNext;
	logic rxEndAsync;

	function automatic logic majority(input logic a, input logic b, input logic c);
		majority = (a & b) | (a & c) | (b & c);
	endfunction : majority

	function automatic logic hitsReg(input logic [7:0] addr, input logic [7:0] offset);
		hitsReg = (addr == offset);
	endfunction : hitsReg

	assign mode = {serial_control_reg_ff.mode_select_high, serial_control_reg_ff.mode_select_low};
	assign isShift = (mode == MODE_SHIFT);
	assign isNine = mode[1];

	// bus slave: zero wait, always OKAY
	assign addrPhase = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == 2'h3);
	assign ctrlWr = wrPend_ff & hitsReg(wrAddr_ff, CTRL_OFFSET);
	assign dataWr = wrPend_ff & hitsReg(wrAddr_ff, DATA_OFFSET);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wrPend_ff <= 1'b0;
			wrAddr_ff <= 8'h00;
		end else if (hready) begin
			wrPend_ff <= addrPhase & hwrite;
			wrAddr_ff <= haddr[7:0];
		end
	end

	// read data registered at the address phase so it stands through the data phase
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hrdata_ff <= 32'h0000_0000;
		end else if (addrPhase & !hwrite) begin
			case (haddr[7:0])
				CTRL_OFFSET: hrdata_ff <= {24'h00_0000, serial_control_reg_ff};
				DATA_OFFSET: hrdata_ff <= {24'h00_0000, rxBuf_ff};
				STATUS_OFFSET: begin
					hrdata_ff <= 32'h0000_0000;
					hrdata_ff[STAT_TX_BUSY_BIT] <= txBusy;
					hrdata_ff[STAT_RX_BUSY_BIT] <= rxBusy;
				end
				default: hrdata_ff <= 32'h0000_0000;
			endcase
		end else begin
			hrdata_ff <= 32'h0000_0000;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hreadyout_ff <= 1'b0;
			hresp_ff <= 1'b0;
		end else begin
			hreadyout_ff <= 1'b1;
			hresp_ff <= 1'b0;
		end
	end

	assign hrdata = hrdata_ff;
	assign hreadyout = hreadyout_ff;
	assign hresp = hresp_ff;

	// rate enables: machine cycle is two clocks, fixed 9-bit tick every four clocks
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mcPhase_ff <= 1'b0;
		end else begin
			mcPhase_ff <= ~mcPhase_ff;
		end
	end

	assign mcEn = mcPhase_ff;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fixDiv_ff <= 2'h0;
		end else if (fixTick) begin
			fixDiv_ff <= 2'h0;
		end else begin
			fixDiv_ff <= fixDiv_ff + 2'h1;
		end
	end

	assign fixTick = (fixDiv_ff == 2'(FIXED9_TICK_CLKS - 1));
	assign tick16 = (mode == MODE_FIXED9) ? fixTick : baudTick16;

	// free-running transmit divide-by-16
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			txCnt_ff <= 4'h0;
		end else if (tick16) begin
			txCnt_ff <= txCnt_ff + 4'h1;
		end
	end

	assign txRoll = tick16 & (txCnt_ff == ROLLOVER);
	assign txStep = isShift ? mcEn : txRoll;
	assign txBusy = (txState_ff != TX_IDLE) | txPend_ff;

	// frame image, bit 0 goes out first
	always_comb begin
		txFrame = 11'h000;
		txLen = MODE0_BITS;
		if (isShift) begin
			txFrame = {3'h0, txHold_ff};
			txLen = MODE0_BITS;
		end else if (isNine) begin
			txFrame = {1'b1, serial_control_reg_ff.tx_ninth_bit, txHold_ff, 1'b0};
			txLen = FRAME9_BITS;
		end else begin
			txFrame = {2'h1, txHold_ff, 1'b0};
			txLen = FRAME8_BITS;
		end
	end

	// transmitter
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			txState_ff <= TX_IDLE;
			txPend_ff <= 1'b0;
			txSh_ff <= 11'h000;
			txLeft_ff <= 4'h0;
			txBit_ff <= 1'b1;
			shiftOut_ff <= 1'b1;
			txFinish_ff <= 1'b0;
		end else begin
			txFinish_ff <= 1'b0;
			if (dataWr) begin
				txPend_ff <= 1'b1;
			end
			case (txState_ff)
				TX_IDLE: begin
					txBit_ff <= 1'b1;
					if (txPend_ff & txStep) begin
						txPend_ff <= dataWr;
						txState_ff <= TX_ACTIVE;
						txSh_ff <= {1'b0, txFrame[10:1]};
						txLeft_ff <= txLen - 4'h1;
						if (isShift) begin
							shiftOut_ff <= txFrame[0];
						end else begin
							txBit_ff <= txFrame[0];
						end
					end
				end
				TX_ACTIVE: begin
					if (txStep) begin
						if (txLeft_ff == 4'h0) begin
							// last bit time has run out
							txState_ff <= TX_IDLE;
							txBit_ff <= 1'b1;
							txFinish_ff <= 1'b1;
						end else begin
							txSh_ff <= {1'b0, txSh_ff[10:1]};
							txLeft_ff <= txLeft_ff - 4'h1;
							if (isShift) begin
								shiftOut_ff <= txSh_ff[0];
							end else begin
								txBit_ff <= txSh_ff[0];
							end
						end
					end
				end
				default: txState_ff <= TX_IDLE;
			endcase
		end
	end

	// shift mode: clock low for one clock from each step edge while either direction shifts
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			txdOut_ff <= 1'b1;
		end else if (isShift) begin
			txdOut_ff <= ~((txState_ff == TX_ACTIVE || rxState_ff == RX_MODE0) & mcEn);
		end else begin
			txdOut_ff <= txBit_ff;
		end
	end

	assign txdOut = txdOut_ff;
	assign shift_data_out_line = shiftOut_ff;

	// receiver
	assign rxBusy = (rxState_ff != RX_IDLE);
	assign vote = majority(rxSamp_ff[0], rxSamp_ff[1], rxdIn);
	assign rxNext = {vote, rxSh_ff[10:1]};
	// start bit reaching rxNext[0] (9-bit) or rxNext[1] (8-bit) marks the end of the frame
	assign rxEndAsync = isNine ? !rxNext[0] : !rxNext[1];

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rxPrev_ff <= 1'b1;
		end else if (tick16) begin
			rxPrev_ff <= rxdIn;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rxState_ff <= RX_IDLE;
			rxSh_ff <= 11'h000;
			rxCnt_ff <= 4'h0;
			rxSamp_ff <= 2'h3;
			rxRes_ff <= '0;
		end else begin
			rxRes_ff.finish <= 1'b0;
			case (rxState_ff)
				RX_IDLE: begin
					if (isShift) begin
						// finish pulse still pending: flag not yet visible
						if (serial_control_reg_ff.receiveEnable & !serial_control_reg_ff.receive_done_flag
								& !rxRes_ff.finish) begin
							rxSh_ff <= {3'h0, RX_SHIFT_PRELOAD};
							rxState_ff <= RX_MODE0;
						end
					end else if (serial_control_reg_ff.receiveEnable & tick16 & rxPrev_ff & !rxdIn) begin
						rxCnt_ff <= 4'h0;
						rxSh_ff <= RX_ASYNC_PRELOAD;
						rxState_ff <= RX_START;
					end
				end
				RX_MODE0: begin
					if (mcEn) begin
						rxSh_ff <= {3'h0, rxSh_ff[6:0], rxdIn};
						if (!rxSh_ff[7]) begin
							rxRes_ff.finish <= 1'b1;
							rxRes_ff.data <= {rxSh_ff[6:0], rxdIn};
							rxState_ff <= RX_IDLE;
						end
					end
				end
				RX_START, RX_FRAME: begin
					if (tick16) begin
						rxCnt_ff <= rxCnt_ff + 4'h1;
						if (rxCnt_ff == SAMPLE_A) begin
							rxSamp_ff[0] <= rxdIn;
						end
						if (rxCnt_ff == SAMPLE_B) begin
							rxSamp_ff[1] <= rxdIn;
						end
						if (rxCnt_ff == SAMPLE_C) begin
							if (rxState_ff == RX_START && vote) begin
								rxState_ff <= RX_IDLE;
							end else begin
								rxSh_ff <= rxNext;
								rxState_ff <= RX_FRAME;
								if (rxState_ff == RX_FRAME && rxEndAsync) begin
									rxState_ff <= RX_IDLE;
									rxRes_ff.finish <= 1'b1;
									rxRes_ff.data <= isNine ? rxNext[8:1] : rxNext[9:2];
									rxRes_ff.ninth <= isNine ? rxNext[9] : rxNext[10];
								end
							end
						end
					end
				end
				default: rxState_ff <= RX_IDLE;
			endcase
		end
	end

	// flag clear written in the finish cycle still lets the new byte in
	assign rxDoneNow = ctrlWr ? hwdata[0] : serial_control_reg_ff.receive_done_flag;
	assign rxAccept = rxRes_ff.finish & !rxDoneNow
		& (isShift | !serial_control_reg_ff.multiproc_filter_en | rxRes_ff.ninth);

	// control, holding and receive buffer registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			serial_control_reg_ff <= CTRL_RESET;
			txHold_ff <= 8'h00;
			rxBuf_ff <= 8'h00;
		end else begin
			if (ctrlWr) begin
				serial_control_reg_ff <= hwdata[7:0];
			end
			if (dataWr) begin
				txHold_ff <= hwdata[7:0];
			end
			// hardware set wins over a software clear
			if (txFinish_ff) begin
				serial_control_reg_ff.transmit_done_flag <= 1'b1;
			end
			if (rxAccept) begin
				rxBuf_ff <= rxRes_ff.data;
				serial_control_reg_ff.receive_done_flag <= 1'b1;
				if (!isShift) begin
					serial_control_reg_ff.rx_ninth_bit <= rxRes_ff.ninth;
				end
			end
		end
	end

	assign txDoneFlag = serial_control_reg_ff.transmit_done_flag;
	assign rxDoneFlag = serial_control_reg_ff.receive_done_flag;

endmodule : four_mode_serial_port

/* File: bench/serial_port_sva.sv */
// checker on the serial port's bus answer and line pins
// assumes bind from the bench top; mode is followed from CTRL writes
`timescale 1ns/100ps
module serial_port_sva import serial_port_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic txdOut,
	input wire logic txDoneFlag,
	input wire logic rxDoneFlag
);
	logic ctrlWr_ff;
	logic [1:0] mode_ff;
	logic [7:0] lowCnt_ff;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrlWr_ff <= 1'b0;
			mode_ff <= MODE_SHIFT;
		end else begin
			ctrlWr_ff <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == CTRL_OFFSET;
			if (ctrlWr_ff)
				mode_ff <= hwdata[7:6];
		end
	end
	// wraps past 255, harmless for the modulo check
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			lowCnt_ff <= 8'h00;
		else
			lowCnt_ff <= txdOut ? 8'h00 : lowCnt_ff + 8'h01;
	end
	sequence s_noXfer;
		!(hsel && hready && htrans[1]);
	endsequence
	sequence s_lowEnds;
		$rose(txdOut);
	endsequence
	property p_okay; hresp == 1'b0; endproperty
	property p_ready; !$past(rst) |-> hreadyout; endproperty
	property p_rdIdle; s_noXfer |=> hrdata == 32'h0; endproperty
	property p_rxClr; $fell(rxDoneFlag) |-> $past(ctrlWr_ff); endproperty
	property p_txClr; $fell(txDoneFlag) |-> $past(ctrlWr_ff); endproperty
	property p_rxHold; rxDoneFlag && !ctrlWr_ff |=> rxDoneFlag; endproperty
	property p_txIdle; $rose(txDoneFlag) |-> txdOut; endproperty
	property p_m0Clk; s_lowEnds ##0 mode_ff == MODE_SHIFT |-> lowCnt_ff == 8'h01; endproperty
	property p_m2Bit; s_lowEnds ##0 mode_ff == MODE_FIXED9 |-> lowCnt_ff[5:0] == 6'h00; endproperty
	a_okay: assert property (p_okay) else $error("bus response not okay");
	a_ready: assert property (p_ready) else $error("wait state inserted");
	a_rdIdle: assert property (p_rdIdle) else $error("read data outside data phase");
	a_rxClr: assert property (p_rxClr) else $error("receive flag dropped unasked");
	a_txClr: assert property (p_txClr) else $error("transmit flag dropped unasked");
	a_rxHold: assert property (p_rxHold) else $error("receive flag not held");
	a_txIdle: assert property (p_txIdle) else $error("line not idle at frame end");
	a_m0Clk: assert property (p_m0Clk) else $error("shift clock low phase wrong");
	a_m2Bit: assert property (p_m2Bit) else $error("fixed rate bit not 64 clocks");
endmodule : serial_port_sva

/* File: bench/serial_node.sv */
// remote serial node facing the port's line pins
// assumes the bench sets nodeMode, bitClks and listen before each transfer
`timescale 1ns/100ps
module serial_node import serial_port_pkg::*; (
	input wire logic core_clk,
	input wire logic txdOut,
	input wire logic shift_data_out_line,
	input wire logic [1:0] nodeMode,
	input wire logic [7:0] bitClks,
	input wire logic listen,
	output logic rxdIn,
	output logic [9:0] gotWord,
	output logic gotPulse
);
	logic [10:0] f;
	logic [7:0] m0Bits = 8'h00;
	logic [3:0] m0Cnt = 4'h0;
	logic sdoLast = 1'b1;
	initial begin
		rxdIn = 1'b1;
		gotPulse = 1'b0;
		gotWord = 10'h000;
	end
	// w[8] is the ninth bit, or the stop bit in mode 1
	task automatic sendFrame(input logic [8:0] w);
		logic [10:0] s;
		s = {1'b1, w, 1'b0};
		for (int k = 0; k < ((nodeMode == MODE_ASYNC8) ? 10 : 11); k++) begin
			@(posedge core_clk);
			rxdIn <= s[k];
			repeat (bitClks - 1) @(posedge core_clk);
		end
		@(posedge core_clk);
		rxdIn <= 1'b1;
	endtask
	// short low pulse, then quiet long enough for the vote to finish
	task automatic glitch(input int n);
		@(posedge core_clk);
		rxdIn <= 1'b0;
		repeat (n) @(posedge core_clk);
		rxdIn <= 1'b1;
		repeat (64) @(posedge core_clk);
	endtask
	task automatic shiftIn(input logic [7:0] b);
		@(posedge core_clk);
		rxdIn <= b[7];
		for (int k = 6; k >= 0; k--) begin
			@(posedge txdOut);
			rxdIn <= b[k];
		end
		@(posedge txdOut);
		rxdIn <= 1'b1;
	endtask
	// stops at mid stop bit so a following frame is not missed
	always @(negedge txdOut) begin
		if (nodeMode != MODE_SHIFT) begin
			f = 11'h7ff;
			repeat (bitClks / 2) @(posedge core_clk);
			for (int k = 0; k < ((nodeMode == MODE_ASYNC8) ? 10 : 11); k++) begin
				if (k > 0)
					repeat (bitClks) @(posedge core_clk);
				f[k] = txdOut;
			end
			gotWord <= {~f[0] & f[10], f[9:1]};
			gotPulse <= 1'b1;
			@(posedge core_clk);
			gotPulse <= 1'b0;
		end
	end
	// port moves its data at the falling clock edge: take the bit that stood just before it
	always @(posedge core_clk) begin
		sdoLast <= shift_data_out_line;
		if (listen && nodeMode == MODE_SHIFT && !txdOut && m0Cnt < 4'h8) begin
			m0Bits <= {sdoLast, m0Bits[7:1]};
			m0Cnt <= m0Cnt + 4'h1;
		end
		if (m0Cnt == 4'h8) begin
			gotWord <= {2'b11, m0Bits};
			gotPulse <= 1'b1;
			m0Cnt <= 4'h9;
		end
		if (m0Cnt == 4'h9) begin
			gotPulse <= 1'b0;
			m0Cnt <= 4'h0;
		end
	end
endmodule : serial_node

/* File: bench/four_mode_serial_port_tb_top.sv */
// bench top: bus master, baud tick, expectation queues and verdict
// assumes the node model and checker files are compiled first
`timescale 1ns/100ps
module four_mode_serial_port_tb_top import serial_port_pkg::*;;
	logic core_clk = 1'b0, rst = 1'b1, hsel, hwrite, rdPhase = 1'b0, listen = 1'b0;
	logic baudTick16 = 1'b0, hready, hreadyout, hresp, rxdIn, txdOut, shift_data_out_line;
	logic txDoneFlag, rxDoneFlag, gotPulse;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, nodeMode = 2'h0, tickCnt = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [7:0] bitClks = 8'h30;
	logic [9:0] gotWord;
	logic [9:0] expQ[$];
	logic [31:0] rdQ[$];
	int nFail = 0;
	int checkCount = 0;
	int seed = 32'hff71;
	assign hready = hreadyout;
	always #25 core_clk = ~core_clk;
	// every third clock, so the variable modes differ from mode 2
	always @(posedge core_clk) begin
		tickCnt <= (tickCnt == 2'h2) ? 2'h0 : tickCnt + 2'h1;
		baudTick16 <= (tickCnt == 2'h2);
	end
	four_mode_serial_port four_mode_serial_port_i (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hrdata, .hreadyout, .hresp, .baudTick16, .rxdIn, .txdOut, .shift_data_out_line,
		.txDoneFlag, .rxDoneFlag);
	serial_node serial_node_i (.core_clk, .txdOut, .shift_data_out_line, .nodeMode, .bitClks, .listen,
		.rxdIn, .gotWord, .gotPulse);
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			nFail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", checkCount, nFail);
		if (nFail == 0 && checkCount > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic busOp(input logic write, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		// upper address bits are random: only the low byte may be decoded
		haddr <= {24'($random(seed)), a};
		hwrite <= write;
		@(posedge core_clk iff hready);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdPhase <= ~write;
		@(posedge core_clk iff hready);
		rdPhase <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		busOp(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rdQ.push_back(e);
		busOp(1'b0, a, 32'h0);
	endtask
	task automatic waitFlag(input logic rx);
		for (int k = 0; k < 3000 && (rx ? rxDoneFlag : txDoneFlag) !== 1'b1; k++)
			@(posedge core_clk);
		chk("flag", {31'h0, rx ? rxDoneFlag : txDoneFlag}, 32'h1);
	endtask
	always @(posedge gotPulse) chk("frame", {22'h0, gotWord}, {22'h0, expQ.pop_front()});
	always @(posedge core_clk) if (rdPhase) chk("hrdata", hrdata, rdQ.pop_front());
	initial begin
		#3_000_000;
		nFail++;
		giveVerdict();
	end
	initial begin
		logic [7:0] d, d2;
		logic nb, n2;
		logic [1:0] mm;
		hsel <= 1'b0;
		hwrite <= 1'b0;
		htrans <= 2'h0;
		haddr <= 32'h0;
		hwdata <= 32'h0;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk iff hreadyout);
		rd(CTRL_OFFSET, 32'h0);
		rd(STATUS_OFFSET, 32'h0);
		wr(8'h0c, $random(seed));
		rd(8'h0c, 32'h0);
		for (int m = 1; m < 4; m++) begin
			mm = m[1:0];
			d = 8'($random(seed));
			{nb, n2, d2} = 10'($random(seed));
			if (mm == MODE_ASYNC8)
				n2 = 1'b1;
			nodeMode <= mm;
			bitClks <= (mm == MODE_FIXED9) ? 8'h40 : 8'h30;
			listen <= 1'b1;
			wr(CTRL_OFFSET, {24'h0, mm, 2'b01, nb, 3'h0});
			expQ.push_back({1'b1, (mm == MODE_ASYNC8) | nb, d});
			fork
				begin
					wr(DATA_OFFSET, {24'h0, d});
					for (int k = 0; k < 70 && txdOut; k++)
						@(posedge core_clk);
					chk("txd start", {31'h0, txdOut}, 32'h0);
				end
				serial_node_i.sendFrame({n2, d2});
			join
			waitFlag(1'b0);
			waitFlag(1'b1);
			rd(DATA_OFFSET, {24'h0, d2});
			rd(CTRL_OFFSET, {24'h0, mm, 2'b01, nb, n2, 2'b11});
			wr(CTRL_OFFSET, 32'h0);
		end
		nodeMode <= MODE_VAR9;
		bitClks <= 8'h30;
		wr(CTRL_OFFSET, {24'h0, MODE_VAR9, 6'h30});
		serial_node_i.sendFrame(9'h05a);
		repeat (4) @(posedge core_clk);
		chk("filtered", {31'h0, rxDoneFlag}, 32'h0);
		serial_node_i.glitch(6);
		serial_node_i.sendFrame(9'h1a5);
		waitFlag(1'b1);
		serial_node_i.sendFrame(9'h13c);
		repeat (4) @(posedge core_clk);
		rd(DATA_OFFSET, 32'ha5);
		nodeMode <= MODE_ASYNC8;
		wr(CTRL_OFFSET, {24'h0, MODE_ASYNC8, 6'h30});
		serial_node_i.sendFrame(9'h011);
		repeat (4) @(posedge core_clk);
		chk("bad stop", {31'h0, rxDoneFlag}, 32'h0);
		wr(CTRL_OFFSET, {24'h0, MODE_ASYNC8, 6'h10});
		serial_node_i.sendFrame(9'h022);
		waitFlag(1'b1);
		rd(CTRL_OFFSET, {24'h0, MODE_ASYNC8, 6'h11});
		listen <= 1'b0;
		nodeMode <= MODE_SHIFT;
		wr(CTRL_OFFSET, 32'h0);
		fork
			serial_node_i.shiftIn(8'hc5);
		join_none
		wr(CTRL_OFFSET, 32'h30);
		// receiver enters its shift state one clock after the control write lands
		@(posedge core_clk);
		rd(STATUS_OFFSET, 32'h2);
		waitFlag(1'b1);
		rd(DATA_OFFSET, 32'hc5);
		listen <= 1'b1;
		expQ.push_back(10'h396);
		wr(DATA_OFFSET, 32'h96);
		rd(STATUS_OFFSET, 32'h1);
		waitFlag(1'b0);
		repeat (4) @(posedge core_clk);
		chk("frames left", expQ.size(), 32'h0);
		giveVerdict();
	end
endmodule : four_mode_serial_port_tb_top
bind four_mode_serial_port serial_port_sva serial_port_sva_i (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .hrdata, .hreadyout, .hresp, .txdOut, .txDoneFlag, .rxDoneFlag);
